/* File: shared/tw_pkg.sv */
`default_nettype none
// ****************************************************************
// shared constants of the two-wire block
// ****************************************************************
package tw_pkg;
	localparam int ADDR_W = 7;
	localparam int DATA_W = 8;
	localparam int BITS_PER_BYTE = 8;
	localparam int CNT_W = 3;
	// reset values
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic MASTER_SEL_RST = 1'b0;
	localparam logic LINE_IDLE = 1'b1;
	// core interrupt entry point
	localparam logic [15:0] IRQ_VECTOR = 16'h003B;
	// position of the read/write bit inside the first byte
	localparam int RW_BIT = 0;
	// spike rejection on the pins, measured on the link clock
	localparam int GLITCH_NS = 50;
	localparam int LINK_PERIOD_NS = 32;
	localparam int GLITCH_CYC_RAW = (GLITCH_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;
	localparam int GLITCH_CYC = (GLITCH_CYC_RAW < 1) ? 1 : GLITCH_CYC_RAW;
	localparam int FILT_CNT_W = 4;
endpackage
`default_nettype wire

/* File: hw/tw_line_filter.sv */
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// pin synchroniser and spike filter, link clock domain
// ****************************************************************
module tw_line_filter #(
	parameter int STABLE_CYCLES = tw_pkg::GLITCH_CYC
) (
	input wire logic link_clk_i,
	input wire logic rstn_i,
	input wire logic line_i,
	output logic level_o
);
	logic s1_ff;
	logic s2_ff;
	logic s3_ff;
	logic level_ff;
	logic [tw_pkg::FILT_CNT_W-1:0] cnt_ff;

	always_ff @(posedge link_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1_ff <= tw_pkg::LINE_IDLE;
			s2_ff <= tw_pkg::LINE_IDLE;
			s3_ff <= tw_pkg::LINE_IDLE;
		end else begin
			s1_ff <= line_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// a new level must hold for the whole spike width before it is believed
	always_ff @(posedge link_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_ff <= '0;
			level_ff <= tw_pkg::LINE_IDLE;
		end else if (s2_ff != s3_ff || s3_ff == level_ff) begin
			cnt_ff <= '0;
		end else if (cnt_ff >= tw_pkg::FILT_CNT_W'(STABLE_CYCLES - 1)) begin
			cnt_ff <= '0;
			level_ff <= s3_ff;
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	assign level_o = level_ff;
endmodule
`default_nettype wire

/* File: hw/tw_core.sv */
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - master select set gives software master, cleared gives hardware slave
// - master mode with drive enable: data line follows software data bit
// - master mode: clock line always driven, following software clock bit
// - drive enable cleared: data line driver released for input
// - drive enable cleared: data line latched into input bit on clock rise
// - after reset the block is in hardware slave mode
// - interface works only while shared port select is cleared
// - slave waits for start, then flags a matching address with direction
// - interrupt reaches core only with peripheral and global enables set
// - a data register access clears the flag and pending interrupt, unless a new flag is set in the same cycle
// - second data access per flag halts slave until interface reset
// - interrupt vectors to fixed address after each acknowledged byte
// - first byte: data register holds address and read/write bit
// - direction bit follows master read/write; set means slave transmits
// - after valid address the clock is held low while flag is set
// - flag set per byte only when followed by acknowledge
// - stop or not-acknowledge returns slave to idle awaiting address
// - interface reset bit forces slave controller to idle
// - interface reset holds slave in reset while set
// - spikes shorter than fifty nanoseconds are filtered on both lines
module tw_core (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic link_clk_i,
	// pins
	input wire logic scl_line_i,
	output logic scl_line_o,
	output logic scl_line_oe_o,
	input wire logic sda_line_i,
	output logic sda_line_o,
	output logic sda_line_oe_o,
	// control
	input wire logic master_select_i,
	input wire logic shared_port_select_i,
	input wire logic iface_reset_bit_i,
	input wire logic sda_drive_enable_i,
	input wire logic sda_out_bit_i,
	input wire logic scl_out_bit_i,
	output logic sda_in_bit_o,
	input wire logic [tw_pkg::ADDR_W-1:0] own_address_reg_i,
	// data register access
	input wire logic data_wr_i,
	input wire logic data_rd_i,
	input wire logic [tw_pkg::DATA_W-1:0] data_wdata_i,
	output logic [tw_pkg::DATA_W-1:0] slave_data_reg_o,
	// status and interrupt
	output logic slave_direction_bit_o,
	output logic byte_done_flag_o,
	output logic halted_o,
	input wire logic peripheral_irq_enable_i,
	input wire logic global_irq_enable_i,
	output logic irq_o,
	output logic [15:0] irq_vector_o
);
	typedef enum logic [2:0] {
		TW_IDLE,
		TW_ADDR,
		TW_ADDR_ACK,
		TW_RX,
		TW_RX_ACK,
		TW_TX,
		TW_TX_ACK,
		TW_HALT
	} tw_state_t;

	// ****************************************************************
	// line filtering and crossing into the core clock
	// ****************************************************************
	logic scl_filt;
	logic sda_filt;
	logic [1:0] x1_ff;
	logic [1:0] x2_ff;
	logic [1:0] x3_ff;
	logic [1:0] lvl_ff;
	logic [1:0] lvl_d_ff;

	tw_line_filter #(.STABLE_CYCLES(tw_pkg::GLITCH_CYC)) u_scl_filt (
		.link_clk_i(link_clk_i),
		.rstn_i(rstn_i),
		.line_i(scl_line_i),
		.level_o(scl_filt)
	);

	tw_line_filter #(.STABLE_CYCLES(tw_pkg::GLITCH_CYC)) u_sda_filt (
		.link_clk_i(link_clk_i),
		.rstn_i(rstn_i),
		.line_i(sda_line_i),
		.level_o(sda_filt)
	);

	// bit 1 is the clock line, bit 0 the data line
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			x1_ff <= {2{tw_pkg::LINE_IDLE}};
			x2_ff <= {2{tw_pkg::LINE_IDLE}};
			x3_ff <= {2{tw_pkg::LINE_IDLE}};
			lvl_ff <= {2{tw_pkg::LINE_IDLE}};
			lvl_d_ff <= {2{tw_pkg::LINE_IDLE}};
		end else begin
			x1_ff <= {scl_filt, sda_filt};
			x2_ff <= x1_ff;
			x3_ff <= x2_ff;
			for (int i = 0; i < 2; i++) begin
				if (x2_ff[i] == x3_ff[i]) begin
					lvl_ff[i] <= x3_ff[i];
				end
			end
			lvl_d_ff <= lvl_ff;
		end
	end

	logic scl_lvl;
	logic sda_lvl;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	assign scl_lvl = lvl_ff[1];
	assign sda_lvl = lvl_ff[0];
	assign scl_rise = scl_lvl && !lvl_d_ff[1];
	assign scl_fall = !scl_lvl && lvl_d_ff[1];
	// data edges only count as start/stop while the clock stays high
	assign start_det = scl_lvl && lvl_d_ff[1] && !sda_lvl && lvl_d_ff[0];
	assign stop_det = scl_lvl && lvl_d_ff[1] && sda_lvl && !lvl_d_ff[0];

	// ****************************************************************
	// mode selection
	// ****************************************************************
	logic iface_on;
	logic master_mode;
	logic slave_run;
	assign iface_on = !shared_port_select_i;
	// reset value of the select input is the slave setting
	assign master_mode = iface_on && (master_select_i != tw_pkg::MASTER_SEL_RST);
	assign slave_run = iface_on && !master_mode && !iface_reset_bit_i;

	// ****************************************************************
	// software master input bit
	// ****************************************************************
	logic sda_in_ff;
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sda_in_ff <= tw_pkg::LINE_IDLE;
		end else if (master_mode && !sda_drive_enable_i && scl_rise) begin
			sda_in_ff <= sda_lvl;
		end
	end
	assign sda_in_bit_o = sda_in_ff;

	// ****************************************************************
	// hardware slave engine
	// ****************************************************************
	tw_state_t state_ff;
	logic [tw_pkg::CNT_W-1:0] bit_cnt_ff;
	logic [tw_pkg::DATA_W-1:0] shift_ff;
	logic [tw_pkg::DATA_W-1:0] data_ff;
	logic dir_ff;
	logic flag_ff;
	logic accessed_ff;
	logic ack_seen_ff;
	logic bit_open_ff; // a rise since the last fall: the fall closing a start holds no bit
	logic access;
	logic flag_set;
	logic byte_end;
	logic addr_match;

	assign access = data_wr_i || data_rd_i;
	assign byte_end = scl_fall && bit_open_ff &&
		(bit_cnt_ff == tw_pkg::CNT_W'(tw_pkg::BITS_PER_BYTE - 1));
	assign addr_match = shift_ff[tw_pkg::DATA_W-1:1] == own_address_reg_i;
	// flag rises when the clock falls at the end of an acknowledged ninth bit
	assign flag_set = slave_run && scl_fall && !start_det && (
		state_ff == TW_ADDR_ACK || state_ff == TW_RX_ACK ||
		(state_ff == TW_TX_ACK && ack_seen_ff));

	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_ff <= TW_IDLE;
			bit_cnt_ff <= '0;
			shift_ff <= tw_pkg::DATA_RST;
			dir_ff <= 1'b0;
			ack_seen_ff <= 1'b0;
			bit_open_ff <= 1'b0;
		end else if (!slave_run) begin
			state_ff <= TW_IDLE;
			bit_cnt_ff <= '0;
			ack_seen_ff <= 1'b0;
		end else if (state_ff == TW_HALT) begin
			// only the interface reset or a disable leaves the halt
		end else if (access && accessed_ff) begin
			state_ff <= TW_HALT;
		end else if (start_det) begin
			state_ff <= TW_ADDR;
			bit_cnt_ff <= '0;
			bit_open_ff <= 1'b0;
		end else if (stop_det) begin
			state_ff <= TW_IDLE;
		end else begin
			bit_open_ff <= scl_rise || (bit_open_ff && !scl_fall);
			case (state_ff)
				TW_IDLE: begin
					bit_cnt_ff <= '0;
				end
				TW_ADDR, TW_RX: begin
					if (scl_rise) begin
						shift_ff <= {shift_ff[tw_pkg::DATA_W-2:0], sda_lvl};
					end
					if (scl_fall && bit_open_ff) begin
						bit_cnt_ff <= bit_cnt_ff + 1'b1;
					end
					if (byte_end) begin
						if (state_ff == TW_RX) begin
							state_ff <= TW_RX_ACK;
						end else if (addr_match) begin
							dir_ff <= shift_ff[tw_pkg::RW_BIT];
							state_ff <= TW_ADDR_ACK;
						end else begin
							state_ff <= TW_IDLE;
						end
					end
				end
				TW_ADDR_ACK, TW_RX_ACK: begin
					if (scl_fall) begin
						bit_cnt_ff <= '0;
						state_ff <= (dir_ff && state_ff == TW_ADDR_ACK) ? TW_TX : TW_RX;
					end
				end
				TW_TX: begin
					if (scl_fall && bit_open_ff) begin
						bit_cnt_ff <= bit_cnt_ff + 1'b1;
					end
					if (byte_end) begin
						state_ff <= TW_TX_ACK;
					end
				end
				TW_TX_ACK: begin
					if (scl_rise) begin
						ack_seen_ff <= !sda_lvl;
					end
					if (scl_fall) begin
						bit_cnt_ff <= '0;
						state_ff <= ack_seen_ff ? TW_TX : TW_IDLE;
					end
				end
				default: begin
					state_ff <= TW_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// data register, flag and access tracking
	// ****************************************************************
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			data_ff <= tw_pkg::DATA_RST;
		end else if (slave_run && byte_end && state_ff == TW_ADDR && addr_match) begin
			data_ff <= shift_ff;
		end else if (slave_run && byte_end && state_ff == TW_RX) begin
			data_ff <= shift_ff;
		end else if (data_wr_i) begin
			data_ff <= data_wdata_i;
		end
	end

	// set beats clear when a byte ends in the same cycle as an access
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flag_ff <= 1'b0;
		end else if (!slave_run) begin
			flag_ff <= 1'b0;
		end else if (flag_set) begin
			flag_ff <= 1'b1;
		end else if (access) begin
			flag_ff <= 1'b0;
		end
	end

	// one access is allowed per flag; the first preload before traffic is allowed too
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			accessed_ff <= 1'b0;
		end else if (!slave_run || flag_set) begin
			accessed_ff <= 1'b0;
		end else if (access) begin
			accessed_ff <= 1'b1;
		end
	end

	// ****************************************************************
	// pin drivers
	// ****************************************************************
	logic stretch;
	logic slave_sda_low;
	logic tx_bit;
	assign tx_bit = data_ff[tw_pkg::CNT_W'(tw_pkg::BITS_PER_BYTE - 1) - bit_cnt_ff];
	assign stretch = slave_run && flag_ff && state_ff != TW_IDLE && state_ff != TW_HALT;
	assign slave_sda_low = slave_run && (
		state_ff == TW_ADDR_ACK || state_ff == TW_RX_ACK ||
		(state_ff == TW_TX && !flag_ff && !tx_bit));

	always_comb begin
		scl_line_o = 1'b0;
		scl_line_oe_o = 1'b0;
		sda_line_o = 1'b0;
		sda_line_oe_o = 1'b0;
		if (master_mode) begin
			scl_line_o = scl_out_bit_i;
			scl_line_oe_o = 1'b1;
			sda_line_o = sda_out_bit_i;
			sda_line_oe_o = sda_drive_enable_i;
		end else begin
			scl_line_oe_o = stretch;
			sda_line_oe_o = slave_sda_low;
		end
	end

	// ****************************************************************
	// status and interrupt outputs
	// ****************************************************************
	assign slave_data_reg_o = data_ff;
	assign slave_direction_bit_o = dir_ff;
	assign byte_done_flag_o = flag_ff;
	assign halted_o = state_ff == TW_HALT;
	// the flag alone cannot tell address from data; software keeps count
	assign irq_o = flag_ff && peripheral_irq_enable_i && global_irq_enable_i;
	assign irq_vector_o = tw_pkg::IRQ_VECTOR;
endmodule
`default_nettype wire

/* File: test/tw_core_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
// ******
// protocol checker
// ******
module tw_core_monitor (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic scl_line_o,
	input wire logic scl_line_oe_o,
	input wire logic sda_line_o,
	input wire logic sda_line_oe_o,
	input wire logic master_select_i,
	input wire logic shared_port_select_i,
	input wire logic iface_reset_bit_i,
	input wire logic sda_drive_enable_i,
	input wire logic sda_out_bit_i,
	input wire logic scl_out_bit_i,
	input wire logic data_wr_i,
	input wire logic data_rd_i,
	input wire logic byte_done_flag_o,
	input wire logic halted_o,
	input wire logic peripheral_irq_enable_i,
	input wire logic global_irq_enable_i,
	input wire logic irq_o,
	input wire logic [15:0] irq_vector_o
);
	logic acc;
	logic sw_on;
	logic slv_on;
	assign acc = data_rd_i || data_wr_i;
	assign sw_on = master_select_i && !shared_port_select_i;
	// the stretch follows the flag, so both drop an edge after the access
	assign slv_on = !master_select_i && !shared_port_select_i && !iface_reset_bit_i
		&& !halted_o && !acc;
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (!rstn_i);
	sequence s_served;
		byte_done_flag_o ##0 acc;
	endsequence
	sequence s_reset_held;
		iface_reset_bit_i ##1 iface_reset_bit_i;
	endsequence
	AST_SCL_FOLLOW: assert property (sw_on |-> scl_line_oe_o && scl_line_o == scl_out_bit_i)
		else $error("clock pin does not follow the software bit");
	AST_SDA_FOLLOW: assert property (sw_on && sda_drive_enable_i |->
		sda_line_oe_o && sda_line_o == sda_out_bit_i)
		else $error("data pin does not follow the software bit");
	AST_SDA_RELEASE: assert property (sw_on && !sda_drive_enable_i |-> !sda_line_oe_o)
		else $error("data pin driven with drive enable low");
	AST_PORT_OFF: assert property (shared_port_select_i |-> !scl_line_oe_o && !sda_line_oe_o)
		else $error("pins driven while the port is given away");
	AST_IRQ_GATE: assert property (irq_o == (byte_done_flag_o && peripheral_irq_enable_i
		&& global_irq_enable_i))
		else $error("interrupt not gated by flag and enables");
	AST_FLAG_CLEAR: assert property (s_served |=> !byte_done_flag_o)
		else $error("flag survives a data access");
	AST_STRETCH: assert property (slv_on && byte_done_flag_o |-> scl_line_oe_o && !scl_line_o)
		else $error("clock not held low while flag is set");
	AST_IFACE_RESET: assert property (s_reset_held |-> !byte_done_flag_o && !halted_o)
		else $error("slave not idle under interface reset");
	AST_VECTOR: assert property (irq_vector_o == 16'h003B)
		else $error("wrong interrupt entry point");
endmodule
bind tw_core tw_core_monitor u_tw_core_monitor (
	.clock_i, .rstn_i, .scl_line_o, .scl_line_oe_o, .sda_line_o, .sda_line_oe_o,
	.master_select_i, .shared_port_select_i, .iface_reset_bit_i, .sda_drive_enable_i,
	.sda_out_bit_i, .scl_out_bit_i, .data_wr_i, .data_rd_i, .byte_done_flag_o, .halted_o,
	.peripheral_irq_enable_i, .global_irq_enable_i, .irq_o, .irq_vector_o
);
`default_nettype wire

/* File: test/tw_bus_master.sv */
`timescale 1ns/1ns
`default_nettype none
// ******
// external bus master, open drain: a 1 releases the line
// ******
module tw_bus_master (
	input wire logic scl_i,
	input wire logic sda_i,
	output logic scl_drv_o,
	output logic sda_drv_o
);
	int half_ns = 1500;
	int n_stuck = 0;
	initial begin
		scl_drv_o = 1'b1;
		sda_drv_o = 1'b1;
	end
	task automatic bit_x(input logic b, output logic got);
		int n;
		n = 0;
		sda_drv_o = b;
		#(half_ns);
		scl_drv_o = 1'b1;
		// the slave may stretch the low phase; give up after 40 us
		while (scl_i !== 1'b1 && n < 4000) begin
			#10;
			n++;
		end
		if (n == 4000)
			n_stuck++;
		#(half_ns);
		got = sda_i;
		scl_drv_o = 1'b0;
	endtask
	task automatic start();
		sda_drv_o = 1'b1;
		#(half_ns);
		scl_drv_o = 1'b1;
		#(half_ns);
		sda_drv_o = 1'b0;
		#(half_ns);
		scl_drv_o = 1'b0;
	endtask
	task automatic stop();
		sda_drv_o = 1'b0;
		#(half_ns);
		scl_drv_o = 1'b1;
		#(half_ns);
		sda_drv_o = 1'b1;
		#(half_ns);
	endtask
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], g);
		bit_x(1'b1, ack);
	endtask
	task automatic get_byte(input logic ack, output logic [7:0] d);
		logic g;
		for (int i = 7; i >= 0; i--)
			bit_x(1'b1, d[i]);
		bit_x(ack, g);
	endtask
	// a clock spike just under the rejection width
	task automatic spike_scl();
		scl_drv_o = 1'b0;
		#40;
		scl_drv_o = 1'b1;
	endtask
	task automatic hold_sda(input logic b);
		sda_drv_o = b;
	endtask
endmodule
`default_nettype wire

/* File: test/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
// ******
// self-checking bench
// ******
module testbench;
	localparam logic [6:0] ADDR = 7'h2A;
	logic clock_i, rstn_i, link_clk_i, master_select_i, shared_port_select_i;
	logic iface_reset_bit_i, sda_drive_enable_i, sda_out_bit_i, scl_out_bit_i;
	logic data_wr_i, data_rd_i, peripheral_irq_enable_i, global_irq_enable_i;
	logic [7:0] data_wdata_i, slave_data_reg_o, d;
	logic [6:0] own_address_reg_i;
	logic scl_line_o, scl_line_oe_o, sda_line_o, sda_line_oe_o, sda_in_bit_o;
	logic slave_direction_bit_o, byte_done_flag_o, halted_o, irq_o, ack;
	logic [15:0] irq_vector_o;
	logic scl_drv, sda_drv, scl_w, sda_w;
	int n_errors = 0;
	int n_compared = 0;
	// pull-ups: any party pulling low wins
	assign scl_w = scl_drv & ~(scl_line_oe_o & ~scl_line_o);
	assign sda_w = sda_drv & ~(sda_line_oe_o & ~sda_line_o);
	initial begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end
	initial begin
		link_clk_i = 1'b0;
		#7;
		forever #16 link_clk_i = ~link_clk_i;
	end
	tw_core u_tw_core (
		.clock_i, .rstn_i, .link_clk_i, .scl_line_i(scl_w), .scl_line_o, .scl_line_oe_o,
		.sda_line_i(sda_w), .sda_line_o, .sda_line_oe_o, .master_select_i,
		.shared_port_select_i, .iface_reset_bit_i, .sda_drive_enable_i, .sda_out_bit_i,
		.scl_out_bit_i, .sda_in_bit_o, .own_address_reg_i, .data_wr_i, .data_rd_i,
		.data_wdata_i, .slave_data_reg_o, .slave_direction_bit_o, .byte_done_flag_o,
		.halted_o, .peripheral_irq_enable_i, .global_irq_enable_i, .irq_o, .irq_vector_o
	);
	tw_bus_master u_tw_bus_master (
		.scl_i(scl_w), .sda_i(sda_w), .scl_drv_o(scl_drv), .sda_drv_o(sda_drv)
	);
	task automatic tick();
		@(posedge clock_i);
		#2;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic test_done();
		if (n_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic access(input logic wr, input logic [7:0] v);
		tick();
		data_wr_i = wr;
		data_rd_i = !wr;
		data_wdata_i = v;
		tick();
		data_wr_i = 1'b0;
		data_rd_i = 1'b0;
		tick();
	endtask
	task automatic wait_flag();
		int n;
		n = 0;
		while (byte_done_flag_o !== 1'b1 && n < 200) begin
			tick();
			n++;
		end
		if (n == 200) begin
			n_errors++;
			test_done();
		end
	endtask
	task automatic address(input logic [6:0] a, input logic rw, input logic exp_ack);
		u_tw_bus_master.start();
		u_tw_bus_master.put_byte({a, rw}, ack);
		check(ack, exp_ack);
		if (!exp_ack)
			wait_flag();
	endtask
	initial begin
		{rstn_i, master_select_i, shared_port_select_i, iface_reset_bit_i} = 4'h0;
		{sda_drive_enable_i, sda_out_bit_i, scl_out_bit_i, data_wr_i, data_rd_i} = 5'h04;
		{peripheral_irq_enable_i, global_irq_enable_i} = 2'h0;
		data_wdata_i = 8'h00;
		own_address_reg_i = ADDR;
		repeat (2) tick();
		rstn_i = 1'b1;
		repeat (20) tick();
		check({byte_done_flag_o, slave_direction_bit_o, halted_o, sda_in_bit_o,
			scl_line_oe_o, sda_line_oe_o, irq_o}, 7'h08);
		check(slave_data_reg_o, 8'h00);
		// write transfer; the first flag is always the address one
		address(ADDR, 1'b0, 1'b0);
		check(slave_data_reg_o, {ADDR, 1'b0});
		check({slave_direction_bit_o, scl_line_oe_o, scl_line_o}, 3'h2);
		for (int k = 0; k < 4; k++) begin
			tick();
			{peripheral_irq_enable_i, global_irq_enable_i} = k[1:0];
			#1 check(irq_o, k == 3);
		end
		access(1'b0, 8'h00);
		check({byte_done_flag_o, irq_o, scl_line_oe_o}, 3'h0);
		u_tw_bus_master.put_byte(8'hC5, ack);
		check(ack, 1'b0);
		wait_flag();
		check(slave_data_reg_o, 8'hC5);
		access(1'b0, 8'h00);
		u_tw_bus_master.stop();
		address(ADDR ^ 7'h01, 1'b0, 1'b1);
		repeat (40) tick();
		check(byte_done_flag_o, 1'b0);
		u_tw_bus_master.stop();
		// read transfer with a slow master
		u_tw_bus_master.half_ns = 2500;
		address(ADDR, 1'b1, 1'b0);
		check(slave_direction_bit_o, 1'b1);
		access(1'b1, 8'h96);
		u_tw_bus_master.get_byte(1'b0, d);
		check(d, 8'h96);
		wait_flag();
		access(1'b1, 8'h3C);
		u_tw_bus_master.get_byte(1'b1, d);
		check(d, 8'h3C);
		repeat (40) tick();
		check({byte_done_flag_o, sda_line_oe_o, scl_line_oe_o}, 3'h0);
		u_tw_bus_master.stop();
		u_tw_bus_master.half_ns = 1500;
		address(ADDR, 1'b0, 1'b0);
		access(1'b0, 8'h00);
		access(1'b0, 8'h00);
		check({halted_o, scl_line_oe_o, sda_line_oe_o}, 3'h4);
		u_tw_bus_master.stop();
		tick();
		iface_reset_bit_i = 1'b1;
		repeat (3) tick();
		check({halted_o, byte_done_flag_o}, 2'h0);
		address(ADDR, 1'b0, 1'b1);
		u_tw_bus_master.stop();
		tick();
		iface_reset_bit_i = 1'b0;
		repeat (20) tick();
		address(ADDR, 1'b0, 1'b0);
		access(1'b0, 8'h00);
		u_tw_bus_master.stop();
		tick();
		shared_port_select_i = 1'b1;
		address(ADDR, 1'b0, 1'b1);
		u_tw_bus_master.stop();
		tick();
		shared_port_select_i = 1'b0;
		tick();
		{master_select_i, scl_out_bit_i, sda_drive_enable_i, sda_out_bit_i} = 4'hA;
		#1 check({scl_line_oe_o, scl_line_o, sda_line_oe_o, sda_line_o}, 4'hA);
		tick();
		sda_out_bit_i = 1'b1;
		#1 check({sda_line_oe_o, sda_line_o}, 2'h3);
		tick();
		sda_drive_enable_i = 1'b0;
		u_tw_bus_master.hold_sda(1'b0);
		#1 check(sda_line_oe_o, 1'b0);
		tick();
		scl_out_bit_i = 1'b1;
		repeat (30) tick();
		u_tw_bus_master.hold_sda(1'b1);
		repeat (30) tick();
		check(sda_in_bit_o, 1'b0);
		scl_out_bit_i = 1'b0;
		repeat (30) tick();
		scl_out_bit_i = 1'b1;
		repeat (30) tick();
		check(sda_in_bit_o, 1'b1);
		u_tw_bus_master.hold_sda(1'b0);
		repeat (30) tick();
		u_tw_bus_master.spike_scl();
		repeat (30) tick();
		check(sda_in_bit_o, 1'b1);
		check(16'(u_tw_bus_master.n_stuck), 16'h0000);
		test_done();
	end
endmodule
`default_nettype wire
